// file: hdl/fpdp_pkg.sv
// Purpose: shared constants and types of the fractional pulse divider pair
// Assumes: one system clock, divider inputs synchronous to it
// Notes:   offsets are byte addresses on the plain register port
package fpdp_pkg;

  // ==========================================================
  // widths
  localparam int unsigned REF_RATIO_W = 6;
  localparam int unsigned IF_RATIO_W  = 5;
  localparam int unsigned CNT_W       = 4;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned PCNT_W      = 16;

  // ==========================================================
  // divider constants
  localparam logic [CNT_W-1:0] END_NORM  = 4'h2; // decoder value
  localparam logic [CNT_W-1:0] END_INC   = 4'h1; // with extra count
  localparam int unsigned      PULSES    = 4;    // pulses per ratio
  // increment pattern, index {ratio_lo, step}, step 0..3
  localparam logic [15:0]      INC_TABLE = 16'hEA40;

  // sequencer codes {first ff, second ff}: LL, HH, LH, HL
  typedef enum logic [1:0] {
    FPDP_SEQ_1 = 2'h0,
    FPDP_SEQ_2 = 2'h3,
    FPDP_SEQ_3 = 2'h1,
    FPDP_SEQ_4 = 2'h2
  } fpdp_seq_t;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned UNLOCK_TIME_NS = 2000; // least lag to flag
  localparam int unsigned UNLOCK_CYC =
    (UNLOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ULK_W = 8;

  // ==========================================================
  // register map
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] REF_PC_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] IF_PC_OFS  = 4'hC;
  localparam logic [2:0]        CTRL_RST   = 3'h7;
  localparam int unsigned       CTRL_REF_EN = 0;
  localparam int unsigned       CTRL_IF_EN  = 1;
  localparam int unsigned       CTRL_PFD_EN = 2;
  localparam int unsigned       ST_UNLOCK   = 0;

endpackage : fpdp_pkg

// file: hdl/fpdp_div_if.sv
// Purpose: carrier between the top and one divider core
// Assumes: tick is a one-cycle pulse per divider input clock
// Notes:   ctl side is the top, core side is the divider
`timescale 1ns/1ns
`default_nettype none
interface fpdp_div_if;
  import fpdp_pkg::*;
  logic                   tick;     // one input clock
  logic [CNT_W-1:0]       ratio_hi; // four high ratio bits
  logic [1:0]             ratio_lo; // two low ratio bits
  logic                   wide;     // ratio of 16 or more
  logic                   pulse;    // output flip-flop
  logic                   ctl;      // count-control flip-flop
  fpdp_seq_t              seq;      // sequencer state

  modport ctl_side (
    output tick, ratio_hi, ratio_lo, wide,
    input  pulse, ctl, seq
  );
  modport core (
    input  tick, ratio_hi, ratio_lo, wide,
    output pulse, ctl, seq
  );
endinterface : fpdp_div_if
`default_nettype wire

// file: hdl/fpdp_div.sv
// Purpose: one divider, four output pulses per ratio input clocks when wide, two otherwise
// Assumes: ratio of 8 or more; smaller ratios wrap the counter
// Notes:   state advances only on ticks from the carrier
`timescale 1ns/1ns
`default_nettype none
module fpdp_div (
  input  wire logic  clk_sys,
  input  wire logic  rstn,
  fpdp_div_if.core   bus
);
  import fpdp_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;   // down-counter
    logic             ctl;   // count-control flip-flop
    logic             out;   // output flip-flop
    fpdp_seq_t        seq;   // ring sequencer
    logic             half;  // halving stage
    logic             start; // first load pending
  } fpdp_div_t;

  fpdp_div_t st;
  fpdp_div_t next_st;
  logic [1:0] step;
  logic       inc;
  logic       tdet;

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    unique case (st.seq)
      FPDP_SEQ_1: step = 2'h0;
      FPDP_SEQ_2: step = 2'h1;
      FPDP_SEQ_3: step = 2'h2;
      FPDP_SEQ_4: step = 2'h3;
    endcase
    inc  = INC_TABLE[{bus.ratio_lo, step}];
    // extra count runs down one further
    tdet = ~st.ctl & (st.cnt == (inc ? END_INC : END_NORM));
    if (bus.tick) begin
      if (st.start | st.ctl) begin
        next_st.cnt   = bus.ratio_hi;
        next_st.ctl   = 1'b0;
        next_st.out   = 1'b0;
        next_st.start = 1'b0;
        if (st.ctl) begin
          unique case (st.seq)
            FPDP_SEQ_1: next_st.seq = FPDP_SEQ_2;
            FPDP_SEQ_2: next_st.seq = FPDP_SEQ_3;
            FPDP_SEQ_3: next_st.seq = FPDP_SEQ_4;
            FPDP_SEQ_4: next_st.seq = FPDP_SEQ_1;
          endcase
        end
      end else begin
        next_st.cnt = st.cnt - 4'h1;
        if (tdet) begin
          next_st.ctl  = 1'b1;
          next_st.half = ~st.half;
          next_st.out  = bus.wide | st.half;
        end
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '{cnt: 4'h0, ctl: 1'b0, out: 1'b0, seq: FPDP_SEQ_1,
              half: 1'b1, start: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign bus.pulse = st.out;
  assign bus.ctl   = st.ctl;
  assign bus.seq   = st.seq;

endmodule : fpdp_div
`default_nettype wire

// file: hdl/fpdp_top.sv
// Purpose: pair of pulse dividers feeding a phase/frequency comparator
// Assumes: divider input clocks and ratio pins synchronous to clk_sys
// Notes:   one divider input clock is one rising edge on its input
//
// How it works
// - four ends of count for every ratio's worth of input clocks
// - spacings are ratio/4, one extra clock per unit of remainder
// - each countdown starts by loading the four high ratio bits
// - every following input clock decrements the counter by one
// - without extra count, end of count detected at value 2
// - next clock sets count-control, output too if halving allows
// - count-control blocks detection, forces load, steps sequencer
// - next clock clears both flip-flops and reloads the counter
// - two low ratio bits choose increment pattern over four steps
// - with increment high counter runs to 1, adding one clock
// - ratio of 16 or more: output follows every end of count
// - ratio below 16: only every other end of count sets output
// - second divider identical, halving from first ratio high bits
// - comparator gives narrow coincident pulses when aligned
// - patterns: 00 LLLL, 01 LLHL, 10 LHLH, 11 LHHH
// - sequencer steps LL, HH, LH, HL and repeats
`timescale 1ns/1ns
`default_nettype none
module fpdp_top (
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic                       ref_clk_in,
  input  wire logic                       if_clk_in,
  input  wire logic                       ref_ratio_bit0,
  input  wire logic                       ref_ratio_bit1,
  input  wire logic                       ref_ratio_bit2,
  input  wire logic                       ref_ratio_bit3,
  input  wire logic                       ref_ratio_bit4,
  input  wire logic                       ref_ratio_bit5,
  input  wire logic                       if_ratio_bit0,
  input  wire logic                       if_ratio_bit1,
  input  wire logic                       if_ratio_bit2,
  input  wire logic                       if_ratio_bit3,
  input  wire logic                       if_ratio_bit4,
  input  wire logic [fpdp_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [fpdp_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [fpdp_pkg::DATA_W-1:0] reg_rdata,
  output logic                            ref_div_out,
  output logic                            if_div_out,
  output logic                            pfd_up,
  output logic                            pfd_dn,
  output logic                            unlock
);
  import fpdp_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic                   ref_prev;  // last ref input level
    logic                   if_prev;   // last if input level
    logic [REF_RATIO_W-1:0] ref_ratio; // captured ref ratio
    logic [IF_RATIO_W-1:0]  if_ratio;  // captured if ratio
    logic [2:0]             ctrl;      // enables
    logic                   ref_pd;    // last ref divider output
    logic                   if_pd;     // last if divider output
    logic                   up;        // comparator up
    logic                   dn;        // comparator down
    logic [ULK_W-1:0]       lag;       // cycles of one-sided drive
    logic                   ulk;       // sticky unlock
    logic [PCNT_W-1:0]      ref_pc;    // ref output pulse count
    logic [PCNT_W-1:0]      if_pc;     // if output pulse count
    logic [DATA_W-1:0]      rdata;     // read answer
  } fpdp_top_t;

  fpdp_top_t st;
  fpdp_top_t next_st;

  fpdp_div_if ref_bus ();
  fpdp_div_if if_bus ();

  logic ref_rise;
  logic if_rise;
  logic one_side;
  logic wr_ctrl;
  logic wr_status;
  logic wr_ref_pc;
  logic wr_if_pc;

  // ==========================================================
  // divider carriers
  // ticks are enabled rising edges of the raw input clocks
  assign ref_bus.tick = ref_clk_in & ~st.ref_prev
                        & st.ctrl[CTRL_REF_EN];
  assign if_bus.tick  = if_clk_in & ~st.if_prev
                        & st.ctrl[CTRL_IF_EN];

  // ratio bits in plain binary, bit0 lowest
  assign ref_bus.ratio_hi = st.ref_ratio[5:2];
  assign ref_bus.ratio_lo = st.ref_ratio[1:0];
  assign if_bus.ratio_hi  = {1'b0, st.if_ratio[4:2]};
  assign if_bus.ratio_lo  = st.if_ratio[1:0];

  // both dividers halve from the ref ratio high bits
  assign ref_bus.wide = |st.ref_ratio[5:4];
  assign if_bus.wide  = |st.ref_ratio[5:4];

  // ==========================================================
  // the two dividers
  fpdp_div u_ref_div (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .bus     (ref_bus.core)
  );

  fpdp_div u_if_div (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .bus     (if_bus.core)
  );

  // ==========================================================
  // comparator inputs and register decode
  assign ref_rise = ref_bus.pulse & ~st.ref_pd;
  assign if_rise  = if_bus.pulse & ~st.if_pd;
  assign one_side = st.up ^ st.dn;

  assign wr_ctrl   = reg_wr & (reg_addr == CTRL_OFS);
  assign wr_status = reg_wr & (reg_addr == STATUS_OFS);
  assign wr_ref_pc = reg_wr & (reg_addr == REF_PC_OFS);
  assign wr_if_pc  = reg_wr & (reg_addr == IF_PC_OFS);

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;

    // input edge history
    next_st.ref_prev = ref_clk_in;
    next_st.if_prev  = if_clk_in;

    // ratio capture from the board pins
    next_st.ref_ratio = {ref_ratio_bit5, ref_ratio_bit4,
                         ref_ratio_bit3, ref_ratio_bit2,
                         ref_ratio_bit1, ref_ratio_bit0};
    next_st.if_ratio  = {if_ratio_bit4, if_ratio_bit3,
                         if_ratio_bit2, if_ratio_bit1,
                         if_ratio_bit0};

    // divider output history
    next_st.ref_pd = ref_bus.pulse;
    next_st.if_pd  = if_bus.pulse;

    // comparator: each side set by its own divider edge,
    // both cleared once both are high, so aligned edges
    // give one-cycle coincident pulses
    if (st.ctrl[CTRL_PFD_EN]) begin
      if (st.up & st.dn) begin
        next_st.up = ref_rise;
        next_st.dn = if_rise;
      end else begin
        next_st.up = st.up | ref_rise;
        next_st.dn = st.dn | if_rise;
      end
    end else begin
      next_st.up = 1'b0;
      next_st.dn = 1'b0;
    end

    // unlock: one side driven too long
    if (one_side) begin
      if (st.lag != ULK_W'(UNLOCK_CYC)) begin
        next_st.lag = st.lag + 8'h01;
      end
    end else begin
      next_st.lag = '0;
    end

    // sticky flag, a write of one clears, a new event wins
    if (wr_status & reg_wdata[ST_UNLOCK]) begin
      next_st.ulk = 1'b0;
    end
    if (one_side & (st.lag == ULK_W'(UNLOCK_CYC - 1))) begin
      next_st.ulk = 1'b1;
    end

    // control register
    if (wr_ctrl) begin
      next_st.ctrl = reg_wdata[2:0];
    end

    // output pulse counters, any write clears
    if (wr_ref_pc) begin
      next_st.ref_pc = '0;
    end
    if (ref_rise) begin
      next_st.ref_pc = next_st.ref_pc + 16'h0001;
    end
    if (wr_if_pc) begin
      next_st.if_pc = '0;
    end
    if (if_rise) begin
      next_st.if_pc = next_st.if_pc + 16'h0001;
    end

    // read answer stands for one cycle only
    next_st.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        CTRL_OFS: begin
          next_st.rdata = {29'h0, st.ctrl};
        end
        STATUS_OFS: begin
          next_st.rdata = {22'h0,
                           if_bus.seq, ref_bus.seq,
                           1'b0,
                           if_bus.pulse, ref_bus.pulse,
                           st.dn, st.up, st.ulk};
        end
        REF_PC_OFS: begin
          next_st.rdata = {16'h0, st.ref_pc};
        end
        IF_PC_OFS: begin
          next_st.rdata = {16'h0, st.if_pc};
        end
        default: begin
          next_st.rdata = '0; // unmapped reads zero
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '{ref_prev:  1'b0,
              if_prev:   1'b0,
              ref_ratio: 6'h00,
              if_ratio:  5'h00,
              ctrl:      CTRL_RST,
              ref_pd:    1'b0,
              if_pd:     1'b0,
              up:        1'b0,
              dn:        1'b0,
              lag:       8'h00,
              ulk:       1'b0,
              ref_pc:    16'h0000,
              if_pc:     16'h0000,
              rdata:     32'h0000_0000};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign reg_rdata   = st.rdata;
  assign ref_div_out = ref_bus.pulse;
  assign if_div_out  = if_bus.pulse;
  assign pfd_up      = st.up;
  assign pfd_dn      = st.dn;
  assign unlock      = st.ulk;

endmodule : fpdp_top
`default_nettype wire

// file: testbench/fpdp_top_sva.sv
// Purpose: port-level checks of the pulse divider pair
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to the top module below the checker
`timescale 1ns/1ns
`default_nettype none
module fpdp_top_sva
  import fpdp_pkg::*;
(
  input wire logic                        clk_sys,
  input wire logic                        rstn,
  input wire logic                        ref_clk_in,
  input wire logic                        if_clk_in,
  input wire logic [fpdp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fpdp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [fpdp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                        ref_div_out,
  input wire logic                        if_div_out,
  input wire logic                        pfd_up,
  input wire logic                        pfd_dn,
  input wire logic                        unlock
);
  localparam int ULK_MIN = UNLOCK_CYC - 2; // slack for registered flag
  logic       rc_q;
  logic       ic_q;
  logic       ro_q;
  logic       ro_q2;
  logic       io_q;
  logic       io_q2;
  logic [7:0] xr_cnt;
  wire        ref_tick = ref_clk_in && !rc_q;
  wire        if_tick  = if_clk_in && !ic_q;
  wire        ref_edge = ref_div_out && !ro_q;
  wire        if_edge  = if_div_out && !io_q;

  // ==========================================================
  // history of inputs and outputs, run length of a lone lead
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rc_q   <= 1'b0;
      ic_q   <= 1'b0;
      ro_q   <= 1'b0;
      ro_q2  <= 1'b0;
      io_q   <= 1'b0;
      io_q2  <= 1'b0;
      xr_cnt <= 8'h00;
    end else begin
      rc_q   <= ref_clk_in;
      ic_q   <= if_clk_in;
      ro_q   <= ref_div_out;
      ro_q2  <= ro_q;
      io_q   <= if_div_out;
      io_q2  <= io_q;
      xr_cnt <= (pfd_up ^ pfd_dn) ? xr_cnt + {7'h00, xr_cnt != 8'hFF}
                                  : 8'h00;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_both;
    pfd_up && pfd_dn;
  endsequence
  sequence s_none;
    !pfd_up && !pfd_dn;
  endsequence

  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside its slot");
  ref_step_a: assert property ($changed(ref_div_out) |-> $past(ref_tick))
    else $error("ref output moved without a tick");
  if_step_a: assert property ($changed(if_div_out) |-> $past(if_tick))
    else $error("if output moved without a tick");
  ref_one_tick_a: assert property (ref_div_out && ref_tick |=> !ref_div_out)
    else $error("ref output held past one tick");
  if_one_tick_a: assert property (if_div_out && if_tick |=> !if_div_out)
    else $error("if output held past one tick");
  // a fresh divider edge in the coincident cycle may set its side again
  pfd_clear_a: assert property (s_both |=> (!pfd_up || $past(ref_edge))
    && (!pfd_dn || $past(if_edge)))
    else $error("coincident pulses not cleared");
  dn_cause_a: assert property ($rose(pfd_dn) |->
    if_edge || (io_q && !io_q2))
    else $error("down without if output edge");
  up_cause_a: assert property ($rose(pfd_up) |->
    (ref_div_out && !ro_q) || (ro_q && !ro_q2))
    else $error("up without ref output edge");
  unlock_hold_a: assert property (unlock && !(reg_wr &&
    reg_addr == STATUS_OFS && reg_wdata[ST_UNLOCK]) |=> unlock)
    else $error("unlock flag dropped");
  unlock_wait_a: assert property ($rose(unlock) |-> xr_cnt >= ULK_MIN)
    else $error("unlock flagged too early");
endmodule : fpdp_top_sva

bind fpdp_top fpdp_top_sva u_sva (
  .clk_sys(clk_sys), .rstn(rstn), .ref_clk_in(ref_clk_in),
  .if_clk_in(if_clk_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ref_div_out(ref_div_out), .if_div_out(if_div_out),
  .pfd_up(pfd_up), .pfd_dn(pfd_dn), .unlock(unlock));
`default_nettype wire

// file: testbench/fpdp_board_model.sv
// Purpose: interface board giving ratios and the divider input clocks
// Assumes: clocks stand low while disabled
// Notes:   if clock low time is set by gap, one cycle at least
`timescale 1ns/1ns
`default_nettype none
module fpdp_board_model (
  input  wire logic       clk_sys,
  input  wire logic       en,
  input  wire logic [5:0] n_val,
  input  wire logic [4:0] m_val,
  input  wire logic [1:0] if_gap,
  output var  logic       ref_clk,
  output var  logic       if_clk,
  output logic      [5:0] n_pins,
  output logic      [4:0] m_pins
);
  logic [1:0] gc;

  // ==========================================================
  // ratios in straight binary, bit0 least significant
  assign n_pins = n_val;
  assign m_pins = m_val;

  initial begin
    ref_clk = 1'b0;
    if_clk  = 1'b0;
    gc      = 2'h0;
  end

  // ref clock toggles each cycle, if clock waits gap+1 cycles low
  always @(posedge clk_sys) begin
    if (!en) begin
      ref_clk <= 1'b0;
      if_clk  <= 1'b0;
      gc      <= 2'h0;
    end else begin
      ref_clk <= !ref_clk;
      if (if_clk) begin
        if_clk <= 1'b0;
      end else if (gc >= if_gap) begin
        if_clk <= 1'b1;
        gc     <= 2'h0;
      end else begin
        gc <= gc + 2'h1;
      end
    end
  end
endmodule : fpdp_board_model
`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: self-checking bench of the pulse divider pair
// Assumes: board model drives ratios and divider clocks
// Notes:   pulse positions counted in input ticks from reset
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fpdp_pkg::*;
  logic              clk_sys, rstn, brd_en, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd;
  logic [5:0]        n_val, n_pins;
  logic [4:0]        m_val, m_pins;
  logic [1:0]        if_gap;
  logic              ref_clk_in, if_clk_in, ref_div_out, if_div_out;
  logic              pfd_up, pfd_dn, unlock, rc_q, ic_q, ro_q, io_q;
  logic [31:0]       seed;
  int                rt, it, ri, mi, error_cnt, cmp_count, cyc, t, k;
  int                corn_n[6] = '{16, 19, 17, 18, 12, 13};

  fpdp_board_model u_brd (.clk_sys(clk_sys), .en(brd_en), .n_val(n_val),
    .m_val(m_val), .if_gap(if_gap), .ref_clk(ref_clk_in),
    .if_clk(if_clk_in), .n_pins(n_pins), .m_pins(m_pins));

  fpdp_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .ref_clk_in(ref_clk_in),
    .if_clk_in(if_clk_in), .ref_ratio_bit0(n_pins[0]),
    .ref_ratio_bit1(n_pins[1]), .ref_ratio_bit2(n_pins[2]),
    .ref_ratio_bit3(n_pins[3]), .ref_ratio_bit4(n_pins[4]),
    .ref_ratio_bit5(n_pins[5]), .if_ratio_bit0(m_pins[0]),
    .if_ratio_bit1(m_pins[1]), .if_ratio_bit2(m_pins[2]),
    .if_ratio_bit3(m_pins[3]), .if_ratio_bit4(m_pins[4]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_div_out(ref_div_out),
    .if_div_out(if_div_out), .pfd_up(pfd_up), .pfd_dn(pfd_dn),
    .unlock(unlock));

  // ==========================================================
  // expectations: extra clock per step, pulse at end of count
  function automatic int inc_of(input int lo, input int s);
    case (lo)
      0: return 0;
      1: return int'(s == 2);
      2: return s % 2;
      default: return int'(s != 0);
    endcase
  endfunction : inc_of

  function automatic int exp_at(input int r, input int half, input int i);
    int sum;
    sum = 0;
    for (int j = 0; j <= i * (half + 1); j++) begin
      sum += r / 4 + inc_of(r % 4, j % 4);
    end
    return sum;
  endfunction : exp_at

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // ==========================================================
  // compares, bus cycles and closing report
  task automatic check_cnt(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      error_cnt++;
      $display("wrong value at %0t: pulse at tick %0d not %0d", $time, got,
               exp);
    end
  endtask : check_cnt

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: read %0h not %0h", $time, got, exp);
    end
  endtask : check_reg

  task automatic reg_read(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : reg_read

  task automatic reg_write(input logic [ADDR_W-1:0] a, input int d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= 32'(d);
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // ==========================================================
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      final_report();
    end
  end

  // ==========================================================
  // monitor: count ticks, check each output pulse position
  always @(posedge clk_sys) begin
    if (!rstn) begin
      rt = 0;
      it = 0;
      ri = 0;
      mi = 0;
    end else begin
      if (ref_div_out && !ro_q) begin
        check_cnt(rt, exp_at(n_val, int'(n_val < 16), ri));
        ri++;
      end
      if (if_div_out && !io_q) begin
        check_cnt(it, exp_at(m_val, int'(n_val < 16), mi));
        mi++;
      end
      rt += int'(ref_clk_in && !rc_q);
      it += int'(if_clk_in && !ic_q);
    end
    rc_q = ref_clk_in;
    ic_q = if_clk_in;
    ro_q = ref_div_out;
    io_q = if_div_out;
  end

  // ==========================================================
  // main sequence: corner ratios first, then random ones
  initial begin
    {rstn, brd_en, reg_wr, reg_rd, rc_q, ic_q, ro_q, io_q} = 8'h00;
    reg_addr  = '0;
    reg_wdata = '0;
    n_val     = 6'h10;
    m_val     = 5'h10;
    if_gap    = 2'h0;
    seed      = 32'h9A6BB633;
    for (t = 0; t < 12; t++) begin
      seed = xs(seed);
      n_val  <= (t < 6) ? 6'(corn_n[t]) : 6'(16 + seed[15:0] % 48);
      m_val  <= 5'(8 + seed[23:16] % 24);
      if_gap <= seed[25:24];
      rstn   <= 1'b0;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      reg_read(STATUS_OFS);
      check_reg(rd, 32'h0);
      reg_read(CTRL_OFS);
      check_reg(rd, 32'(CTRL_RST));
      reg_read(4'h2);
      check_reg(rd, 32'h0);
      brd_en <= 1'b1;
      for (k = 0; k < 5000 && (ri < 8 || mi < 8); k++) @(posedge clk_sys);
      check_reg(32'(k < 5000), 32'h1);
      brd_en <= 1'b0;
      repeat (4) @(posedge clk_sys);
      reg_read(REF_PC_OFS);
      check_reg(rd, 32'(ri));
      reg_read(IF_PC_OFS);
      check_reg(rd, 32'(mi));
      // comparator off drops up and down, then unlock is cleared
      reg_write(CTRL_OFS, 0);
      reg_write(STATUS_OFS, 1);
      reg_read(STATUS_OFS);
      check_reg(rd[2:0], 32'h0);
      reg_read(CTRL_OFS);
      check_reg(rd, 32'h0);
      $display("test %0d done: ratios %0d and %0d", t, n_val, m_val);
    end
    final_report();
  end
endmodule : tb_top
`default_nettype wire
